// [core/tws_eeprom.sv]
/*
  Command decoder and array sequencer of a 64 x 16 three-wire serial memory.
  Assumes the host pins arrive asynchronously and are sampled by ref_clk.
*/
module tws_eeprom #(
  parameter int PROG_CYCLES = tws_pkg::PROG_CYCLE_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Host serial pins
  input  wire logic chip_select,
  input  wire logic shift_clock,
  input  wire logic serial_in,
  // Serial data out, three-state
  output logic      serial_out,
  output logic      serial_out_oe,
  // Programming activity
  output logic      program_busy
);
  import tws_pkg::*;

  // ********************************
  // Pin synchronisers
  // ********************************
  logic cs_meta, cs_sync, cs_prev;
  logic clk_meta, clk_sync, clk_prev;
  logic din_meta, din_sync;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cs_meta  <= 1'b0;
      cs_sync  <= 1'b0;
      cs_prev  <= 1'b0;
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      cs_meta  <= chip_select;
      cs_sync  <= cs_meta;
      cs_prev  <= cs_sync;
      clk_meta <= shift_clock;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      din_meta <= serial_in;
      din_sync <= din_meta;
    end
  end

  logic shift_rise;
  logic cs_rise;
  assign shift_rise = cs_sync && clk_sync && !clk_prev;
  assign cs_rise    = cs_sync && !cs_prev;

  // ********************************
  // Select low time
  // ********************************
  logic [LOW_CNT_W-1:0] low_cnt;
  logic                 low_long;
  assign low_long = (low_cnt == LOW_CNT_W'(SELECT_LOW_CYC));

  always_ff @(posedge ref_clk) begin
    if (!reset_n || cs_sync) begin
      low_cnt <= '0;
    end else if (!low_long) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // ********************************
  // Instruction decoder
  // ********************************
  tws_rx_t     rx;
  logic [3:0]  bit_cnt;
  logic [7:0]  head;
  logic [15:0] data_sr;
  logic [7:0]  next_head;
  logic [1:0]  cur_op;
  logic [1:0]  cur_sub;
  logic        head_done;
  logic        data_done;

  assign next_head = {head[6:0], din_sync};
  assign cur_op    = next_head[7:6];
  assign cur_sub   = next_head[5:4];
  assign head_done = shift_rise && rx == RX_HEAD &&
                     bit_cnt == 4'(HEAD_BITS - 1);
  assign data_done = shift_rise && rx == RX_DATA && bit_cnt == 4'hf;

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !cs_sync) begin
      rx      <= RX_IDLE;
      bit_cnt <= 4'h0;
    end else if (shift_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
      case (rx)
        RX_IDLE: begin
          bit_cnt <= 4'h0;
          if (din_sync) begin
            rx <= RX_HEAD;
          end
        end
        RX_HEAD: begin
          if (head_done) begin
            bit_cnt <= 4'h0;
            if (cur_op == OP_READ) begin
              rx <= RX_READ;
            end else if (cur_op == OP_WRITE ||
                         (cur_op == OP_SPECIAL &&
                          cur_sub == SUB_WRITE_ALL)) begin
              rx <= RX_DATA;
            end else begin
              rx <= RX_DONE;
            end
          end
        end
        RX_DATA: begin
          if (data_done) begin
            rx <= RX_DONE;
          end
        end
        RX_READ: begin
          if (bit_cnt == 4'hf) begin
            rx <= RX_DONE;
          end
        end
        RX_DONE: begin
          rx <= RX_DONE;
        end
        default: begin
          rx <= RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      head    <= 8'h00;
      data_sr <= 16'h0000;
    end else if (rx == RX_HEAD && shift_rise) begin
      head <= next_head;
    end else if (rx == RX_DATA && shift_rise) begin
      data_sr <= {data_sr[14:0], din_sync};
    end
  end

  // ********************************
  // Programming permission
  // ********************************
  logic prog_enabled;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prog_enabled <= 1'b0;
    end else if (head_done && cur_op == OP_SPECIAL) begin
      if (cur_sub == SUB_ENABLE) begin
        prog_enabled <= 1'b1;
      end else if (cur_sub == SUB_DISABLE) begin
        prog_enabled <= 1'b0;
      end
    end
  end

  // ********************************
  // Programming jobs
  // ********************************
  logic             job_valid;
  logic             job_ready;
  tws_job_t         job_kind;
  logic [15:0]      job_word;
  logic [5:0]       job_addr;
  logic             q_valid;
  logic             q_ready;
  logic [JOB_W-1:0] q_data;
  tws_job_t         q_kind;

  always_comb begin
    job_valid = 1'b0;
    job_kind  = TWS_JOB_ERASE;
    job_word  = {data_sr[14:0], din_sync};
    // Erase queues at decode, writes after data: header already held
    job_addr  = head_done ? next_head[5:0] : head[5:0];
    if (head_done && prog_enabled) begin
      if (cur_op == OP_ERASE) begin
        job_valid = 1'b1;
      end else if (cur_op == OP_SPECIAL &&
                   cur_sub == SUB_ERASE_ALL) begin
        job_valid = 1'b1;
        job_kind  = TWS_JOB_ERASE_ALL;
      end
    end else if (data_done && prog_enabled) begin
      job_valid = 1'b1;
      job_kind  = (head[7:6] == OP_WRITE) ? TWS_JOB_WRITE
                                          : TWS_JOB_WRITE_ALL;
    end
  end

  tws_fifo #(
    .WIDTH (JOB_W),
    .DEPTH (FIFO_DEPTH)
  ) u_jobs (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (job_valid),
    .in_ready  (job_ready),
    .in_data   ({job_kind, job_addr, job_word}),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  assign q_kind = tws_job_t'(q_data[JOB_W-1 -: 2]);

  // ********************************
  // Array sequencer
  // ********************************
  tws_seq_t           seq;
  logic [TIMER_W-1:0] timer;
  logic [ADDR_W-1:0]  wr_addr;
  logic [15:0]        pattern;
  logic               all_words;
  logic               busy;
  logic [15:0]        mem [WORDS];
  logic [15:0]        mem_q;

  assign q_ready = (seq == SQ_IDLE);
  assign busy    = (seq != SQ_IDLE) || q_valid;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      seq       <= SQ_IDLE;
      timer     <= '0;
      wr_addr   <= '0;
      pattern   <= 16'h0000;
      all_words <= 1'b0;
    end else begin
      case (seq)
        SQ_IDLE: begin
          if (q_valid) begin
            seq       <= SQ_FILL;
            all_words <= q_kind == TWS_JOB_ERASE_ALL ||
                         q_kind == TWS_JOB_WRITE_ALL;
            wr_addr   <= (q_kind == TWS_JOB_ERASE ||
                          q_kind == TWS_JOB_WRITE) ?
                         q_data[DATA_W +: ADDR_W] : '0;
            pattern   <= (q_kind == TWS_JOB_ERASE ||
                          q_kind == TWS_JOB_ERASE_ALL) ?
                         ERASED_WORD : q_data[DATA_W-1:0];
          end
        end
        SQ_FILL: begin
          if (!all_words || wr_addr == ADDR_W'(WORDS - 1)) begin
            seq   <= SQ_WAIT;
            timer <= '0;
          end else begin
            wr_addr <= wr_addr + 1'b1;
          end
        end
        SQ_WAIT: begin
          timer <= timer + 1'b1;
          if (timer == TIMER_W'(PROG_CYCLES - 1)) begin
            seq <= SQ_IDLE;
          end
        end
        default: begin
          seq <= SQ_IDLE;
        end
      endcase
    end
  end

  // Array contents survive reset
  always_ff @(posedge ref_clk) begin
    if (seq == SQ_FILL) begin
      mem[wr_addr] <= pattern;
    end
    mem_q <= mem[head[5:0]];
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      program_busy <= 1'b0;
    end else begin
      program_busy <= busy;
    end
  end

  // ********************************
  // Ready/busy status
  // ********************************
  logic armed;
  logic status_on;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      armed <= 1'b0;
    end else if (job_valid && job_ready) begin
      armed <= 1'b1;
    end else if (cs_rise) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      status_on <= 1'b0;
    end else if (cs_rise) begin
      status_on <= armed && busy && low_long;
    end else if (!cs_sync || (shift_rise && rx == RX_IDLE && din_sync)) begin
      status_on <= 1'b0;
    end
  end

  // ********************************
  // Serial output
  // ********************************
  logic [1:0]  load_dly;
  logic [15:0] read_sr;
  logic        read_active;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      load_dly <= 2'h0;
      read_sr  <= 16'h0000;
    end else begin
      load_dly <= {load_dly[0], head_done && cur_op == OP_READ};
      if (load_dly[1]) begin
        read_sr <= mem_q;
      end else if (shift_rise && rx == RX_READ) begin
        read_sr <= {read_sr[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !cs_sync) begin
      read_active <= 1'b0;
    end else if (head_done && cur_op == OP_READ) begin
      read_active <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (!cs_sync) begin
      serial_out_oe <= 1'b0;
    end else if (head_done && cur_op == OP_READ) begin
      serial_out_oe <= 1'b1;
      serial_out    <= 1'b0;
    end else if (shift_rise && rx == RX_READ) begin
      serial_out <= read_sr[15];
    end else if (status_on) begin
      serial_out_oe <= 1'b1;
      serial_out    <= !busy;
    end else if (!read_active) begin
      serial_out_oe <= 1'b0;
    end
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_read_decode;
    head_done && cur_op == OP_READ;
  endsequence

  sequence s_special(logic [1:0] sub);
    head_done && cur_op == OP_SPECIAL && cur_sub == sub;
  endsequence

  sequence s_bulk_start;
    seq == SQ_IDLE && q_valid &&
    (q_kind == TWS_JOB_ERASE_ALL || q_kind == TWS_JOB_WRITE_ALL);
  endsequence

  a_select_low_release: assert property (
    !cs_sync |=> !serial_out_oe && rx == RX_IDLE)
    else $error("serial out driven while select low");
  a_dummy_bit_zero: assert property (
    s_read_decode |=> serial_out_oe && !serial_out ##1 !serial_out)
    else $error("read dummy bit not zero");
  a_enable_sets: assert property (
    s_special(SUB_ENABLE) |=> prog_enabled)
    else $error("enable instruction ignored");
  a_disable_clears: assert property (
    s_special(SUB_DISABLE) |=> !prog_enabled)
    else $error("disable instruction ignored");
  a_enable_holds: assert property (
    prog_enabled && !(head_done && cur_op == OP_SPECIAL &&
                      cur_sub == SUB_DISABLE) |=> prog_enabled)
    else $error("programming permission lost");
  a_protect_blocks: assert property (
    !prog_enabled && !busy |=> !busy)
    else $error("programming job while protected");
  a_erase_starts: assert property (
    head_done && cur_op == OP_ERASE && prog_enabled && job_ready
    |=> busy ##1 busy)
    else $error("erase did not start at decode");
  a_read_edge_only: assert property (
    read_active && $past(read_active) && !status_on &&
    $changed(serial_out) |-> $past(shift_rise))
    else $error("read data changed off a clock edge");
  a_status_shown: assert property (
    cs_rise && armed && busy && low_long |=> status_on)
    else $error("status not presented");
  a_status_late: assert property (
    cs_rise && !busy |=> !status_on ##1 !status_on)
    else $error("status shown after programming ended");
  a_bulk_fill: assert property (
    s_bulk_start |=> (seq == SQ_FILL) [*8])
    else $error("bulk fill cut short");

endmodule

// [core/tws_fifo.sv]
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
module tws_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;

  assign in_ready  = (wr_ptr[PW] == rd_ptr[PW]) ||
                     (wr_ptr[PW-1:0] != rd_ptr[PW-1:0]);
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = store[rd_ptr[PW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (in_valid && in_ready) begin
      store[wr_ptr[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule

// [core/tws_pkg.sv]
/*
  Shared constants and types of the three-wire serial memory block.
  Assumes a 125 MHz core clock; all pin timing is counted in its cycles.
*/
package tws_pkg;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_NS   = 8;
  localparam int SELECT_LOW_NS   = 250;
  localparam int SELECT_LOW_CYC  =
    (SELECT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLE_MS   = 10;
  localparam int PROG_CYCLE_CYC  = PROG_CYCLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LOW_CNT_W       = 6;
  localparam int TIMER_W         = 21;

  // ********************************
  // Geometry
  // ********************************
  localparam int ADDR_W     = 6;
  localparam int DATA_W     = 16;
  localparam int WORDS      = 64;
  localparam int HEAD_BITS  = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int JOB_W      = 2 + ADDR_W + DATA_W;

  // ********************************
  // Op codes and sub-codes
  // ********************************
  localparam logic [1:0] OP_SPECIAL     = 2'h0;
  localparam logic [1:0] OP_WRITE       = 2'h1;
  localparam logic [1:0] OP_READ        = 2'h2;
  localparam logic [1:0] OP_ERASE       = 2'h3;
  localparam logic [1:0] SUB_DISABLE    = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL  = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL  = 2'h2;
  localparam logic [1:0] SUB_ENABLE     = 2'h3;
  localparam logic [15:0] ERASED_WORD   = 16'hffff;

  typedef enum logic [1:0] {
    TWS_JOB_ERASE, TWS_JOB_WRITE, TWS_JOB_ERASE_ALL, TWS_JOB_WRITE_ALL
  } tws_job_t;

  typedef enum {RX_IDLE, RX_HEAD, RX_DATA, RX_READ, RX_DONE} tws_rx_t;
  typedef enum {SQ_IDLE, SQ_FILL, SQ_WAIT} tws_seq_t;

endpackage

// [testbench/tws_eeprom_tb.sv]
/*
  Self-checking bench of the serial memory block.
  Assumes tws_pkg, tws_eeprom and tws_host_model are compiled first.
*/
module tws_eeprom_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tws_pkg::*;

  localparam int PROG = 400;

  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        chip_select;
  logic        shift_clock;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_oe;
  logic        program_busy;
  logic        rd_valid;
  logic        rd_dummy;
  logic [15:0] rd_word;
  int          mismatches = 0;
  int          samples_checked = 0;
  logic [15:0] exp_q[$];
  logic [15:0] mem[WORDS];
  logic [31:0] rng = 32'hd1b2;
  bit          enabled = 1'b0;

  always #4 ref_clk = ~ref_clk;

  tws_eeprom #(.PROG_CYCLES(PROG)) i_tws_eeprom (
    .ref_clk(ref_clk), .reset_n(reset_n), .chip_select(chip_select),
    .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .program_busy(program_busy));

  tws_host_model u_host (
    .ref_clk(ref_clk), .chip_select(chip_select),
    .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .rd_valid(rd_valid), .rd_dummy(rd_dummy), .rd_word(rd_word));

  // ************************************
  // Helpers
  // ************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Instruction with its expected effect and status
  task automatic issue(input logic [1:0] op, input logic [5:0] a,
                       input logic [15:0] d);
    logic f;
    logic l;
    int   w;
    bit   hasd;
    bit   job;
    hasd = op == OP_WRITE || (op == OP_SPECIAL && a[5:4] == SUB_WRITE_ALL);
    job = op == OP_ERASE || hasd ||
          (op == OP_SPECIAL && a[5:4] == SUB_ERASE_ALL);
    if (hasd)
      u_host.frame({1'b1, op, a, d}, 25, 1'b0);
    else
      u_host.frame({16'h0000, 1'b1, op, a}, 9, 1'b0);
    if (!job) begin
      enabled = (a[5:4] == SUB_ENABLE);
    end else if (!enabled) begin
      check("busy protected", {15'h0, program_busy}, 16'h0000);
    end else begin
      check("busy queued", {15'h0, program_busy}, 16'h0001);
      for (int i = 0; i < WORDS; i++) begin
        if (op == OP_SPECIAL || i == int'(a))
          mem[i] = hasd ? d : ERASED_WORD;
      end
      u_host.poll_status(f, l, w);
      check("status busy", {15'h0, f}, 16'h0000);
      check("status ready", {15'h0, l}, 16'h0001);
      check("status wait", 16'(w < 2000), 16'h0001);
    end
  endtask

  task automatic rd(input logic [5:0] a);
    exp_q.push_back(mem[a]);
    u_host.frame({16'h0000, 1'b1, OP_READ, a}, 9, 1'b1);
    check("oe deselected", {15'h0, serial_out_oe}, 16'h0000);
  endtask

  // ************************************
  // Read monitor
  // ************************************
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("wrong value read count expected none seen one");
      end else begin
        check("dummy bit", {15'h0, rd_dummy}, 16'h0000);
        check("read word", rd_word, exp_q.pop_front());
      end
    end
  end

  initial begin
    #400000;
    mismatches++;
    complete_run();
  end

  // ************************************
  // Main sequence
  // ************************************
  initial begin
    logic oe_seen;
    int   n;
    repeat (16) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    check("oe reset", {15'h0, serial_out_oe}, 16'h0000);
    check("busy reset", {15'h0, program_busy}, 16'h0000);
    issue(OP_WRITE, 6'h05, 16'h1234);
    issue(OP_SPECIAL, {SUB_ERASE_ALL, 4'h0}, 16'h0000);
    issue(OP_SPECIAL, {SUB_ENABLE, 4'ha}, 16'h0000);
    issue(OP_SPECIAL, {SUB_ERASE_ALL, 4'h5}, 16'h0000);
    rd(6'h00);
    rd(6'h3f);
    issue(OP_SPECIAL, {SUB_WRITE_ALL, 4'h3}, 16'ha55a);
    rd(6'h00);
    rd(6'h1f);
    rd(6'h3f);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      issue(OP_WRITE, rng[5:0], rng[31:16]);
      rd(rng[5:0]);
    end
    issue(OP_ERASE, rng[5:0], 16'h0000);
    rd(rng[5:0]);
    u_host.frame({1'b1, OP_WRITE, 6'h07, 16'h0ff0}, 25, 1'b0);
    mem[7] = 16'h0ff0;
    n = 0;
    while (program_busy !== 1'b0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    check("busy end", 16'(n < 2000), 16'h0001);
    u_host.peek_select(oe_seen);
    check("late status", {15'h0, oe_seen}, 16'h0000);
    exp_q.push_back(mem[7]);
    u_host.frame({14'h0, 2'b00, 1'b1, OP_READ, 6'h07}, 11, 1'b1);
    issue(OP_SPECIAL, {SUB_DISABLE, 4'hf}, 16'h0000);
    issue(OP_ERASE, 6'h07, 16'h0000);
    issue(OP_SPECIAL, {SUB_WRITE_ALL, 4'h0}, 16'h1111);
    rd(6'h07);
    rd(6'h00);
    n = 0;
    while (exp_q.size() != 0 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    check("reads done", 16'(exp_q.size()), 16'h0000);
    complete_run();
  end
endmodule

// [testbench/tws_host_model.sv]
/*
  Host controller model driving the three-wire serial pins.
  Assumes a memory that samples the pins with ref_clk and drives
  serial_out only while serial_out_oe is high.
*/
module tws_host_model (
  // Core clock, for bounded waits
  input  wire logic   ref_clk,
  // Pins toward the memory
  output logic        chip_select,
  output logic        shift_clock,
  output logic        serial_in,
  input  wire logic   serial_out,
  input  wire logic   serial_out_oe,
  // Read results
  output logic        rd_valid,
  output logic        rd_dummy,
  output logic [15:0] rd_word
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    chip_select = 1'b0;
    shift_clock = 1'b0;
    serial_in = 1'b0;
    rd_valid = 1'b0;
    rd_dummy = 1'b0;
    rd_word = 16'h0000;
  end

  // ************************************
  // Bit and frame level
  // ************************************
  // One 125 ns period; output looked at just before the fall
  task automatic shift_bit(input logic b, output logic seen);
    serial_in = b;
    #62.5;
    shift_clock = 1'b1;
    #62.5;
    seen = serial_out_oe ? serial_out : ~serial_out;
    shift_clock = 1'b0;
  endtask

  // Select rise, n bits MSB first, optional 16-bit read tail; dummy bit taken on the last header bit
  task automatic frame(input logic [24:0] bits, input int n, input bit rd);
    logic        s;
    logic [16:0] got;
    @(posedge ref_clk);
    #1;
    chip_select = 1'b1;
    #62.5;
    for (int i = n - 1; i >= 0; i--) begin
      shift_bit(bits[i], s);
    end
    if (rd) begin
      got[16] = s;
      for (int i = 15; i >= 0; i--) begin
        shift_bit(1'b0, got[i]);
      end
      rd_dummy = got[16];
      rd_word = got[15:0];
      @(posedge ref_clk);
      #1 rd_valid = 1'b1;
      @(posedge ref_clk);
      #1 rd_valid = 1'b0;
    end
    chip_select = 1'b0;
    serial_in = ~serial_in;
    #400;
  endtask

  // Select high after a job; wait for ready under a bound
  task automatic poll_status(output logic first, output logic last,
                             output int waited);
    @(posedge ref_clk);
    #1;
    chip_select = 1'b1;
    waited = 0;
    repeat (8) @(posedge ref_clk);
    first = serial_out_oe ? serial_out : ~serial_out;
    while ((serial_out_oe ? serial_out : ~serial_out) !== 1'b1 &&
           waited < 2000) begin
      @(posedge ref_clk);
      waited++;
    end
    last = serial_out_oe ? serial_out : ~serial_out;
    chip_select = 1'b0;
    #400;
  endtask

  // Bare select pulse, no bits
  task automatic peek_select(output logic oe_seen);
    @(posedge ref_clk);
    #1;
    chip_select = 1'b1;
    repeat (8) @(posedge ref_clk);
    oe_seen = serial_out_oe;
    chip_select = 1'b0;
    #400;
  endtask
endmodule
